// *** design/count_prescaler.sv ***
// internal count clock divider, one-cycle tick per count clock
`timescale 1ns/100ps
`default_nettype none
module count_prescaler (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] sel,
  output logic tick
);
  import timer_pkg::*;

  logic [7:0] div;
  logic [7:0] mask;

  always_comb begin
    unique case (sel)
      CLK_DIV2: mask = MASK_DIV2;
      CLK_DIV16: mask = MASK_DIV16;
      default: mask = MASK_DIV256;
    endcase
  end

  assign tick = ((div & mask) == mask);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end
endmodule : count_prescaler
`default_nettype wire

// *** design/pin_edge_detect.sv ***
// synchroniser and valid-edge detector for one timer input pin
`timescale 1ns/100ps
`default_nettype none
module pin_edge_detect (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  input wire timer_pkg::edge_sel_t sel,
  output logic valid_edge,
  output logic reverse_edge
);
  import timer_pkg::*;

  logic sync_1;
  logic sync_2;
  logic last;
  wire rise = sync_2 & ~last;
  wire fall = ~sync_2 & last;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      last <= 1'b0;
    end else begin
      sync_1 <= pin;
      sync_2 <= sync_1;
      last <= sync_2;
    end
  end

  // reverse phase only exists for a single-edge selection
  always_comb begin
    unique case (sel)
      EDGE_FALL: begin
        valid_edge = fall;
        reverse_edge = rise;
      end
      EDGE_RISE: begin
        valid_edge = rise;
        reverse_edge = fall;
      end
      EDGE_NONE: begin
        valid_edge = 1'b0;
        reverse_edge = 1'b0;
      end
      EDGE_BOTH: begin
        valid_edge = rise | fall;
        reverse_edge = 1'b0;
      end
    endcase
  end
endmodule : pin_edge_detect
`default_nettype wire

// *** design/timer_event_counter.sv ***
// 16-bit timer/event counter with two capture/compare registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module timer_event_counter (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [timer_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [timer_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [timer_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [timer_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TIMER_INPUT_A,
  input wire logic TIMER_INPUT_B,
  output logic TIMER_OUTPUT,
  output logic MATCH_IRQ_A,
  output logic MATCH_IRQ_B
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] timer_count;
  logic [CNT_W-1:0] capture_compare_a;
  logic [CNT_W-1:0] capture_compare_b;
  run_mode_t run_mode;
  logic overflow;
  logic [2:0] capcomp_control;
  logic [7:0] output_control;
  logic [5:0] prescaler_mode;
  logic oneshot_trigger;
  logic out_level;

  logic [ADDR_W-1:0] aw_addr;
  logic aw_full;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic w_full;

  // ----------------------------------------------------------------
  // pin edges and count clock
  // ----------------------------------------------------------------
  logic valid_a;
  logic reverse_a;
  logic valid_b;
  logic pre_tick;

  pin_edge_detect u_edge_a (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .pin(TIMER_INPUT_A),
    .sel(edge_sel_t'(prescaler_mode[PRE_EDGE_A_LO +: 2])),
    .valid_edge(valid_a),
    .reverse_edge(reverse_a)
  );

  pin_edge_detect u_edge_b (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .pin(TIMER_INPUT_B),
    .sel(edge_sel_t'(prescaler_mode[PRE_EDGE_B_LO +: 2])),
    .valid_edge(valid_b),
    .reverse_edge()
  );

  count_prescaler u_presc (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .sel(prescaler_mode[PRE_CLK_LO +: 2]),
    .tick(pre_tick)
  );

  wire [1:0] clk_sel = prescaler_mode[PRE_CLK_LO +: 2];
  wire running = (run_mode != RUN_STOP);
  // external event counting takes input a edges as the count clock
  wire tick = (clk_sel == CLK_EXT_A) ? valid_a : pre_tick;

  // ----------------------------------------------------------------
  // compare, capture and clear decisions
  // ----------------------------------------------------------------
  wire capture_a = capcomp_control[CC_A_CAPTURE];
  wire capture_b = capcomp_control[CC_B_CAPTURE];
  wire rev_trig_a = capcomp_control[CC_A_REVPHASE];
  wire oneshot_mode = output_control[OUT_ONESHOT];

  wire eq_a = (timer_count == capture_compare_a);
  wire eq_b = (timer_count == capture_compare_b);
  wire match_a = running & tick & ~capture_a & eq_a;
  wire match_b = running & tick & ~capture_b & eq_b;
  // a register in compare mode ignores every capture trigger
  wire trig_a = rev_trig_a ? reverse_a : valid_b;
  wire cap_a = running & capture_a & trig_a;
  wire cap_b = running & capture_b & valid_a;

  wire clr_edge = (run_mode == RUN_CLR_EDGE) & valid_a;
  wire clr_match = (run_mode == RUN_CLR_MATCH) & tick & eq_a;
  wire clr_oneshot = oneshot_mode &
                     (oneshot_trigger |
                      (output_control[OUT_OS_EDGE] & valid_a));
  wire wrap = tick & (timer_count == COUNT_MAX);
  wire any_clear = clr_edge | clr_match | clr_oneshot;

  logic [CNT_W-1:0] next_timer_count;
  always_comb begin
    if (!running) begin
      next_timer_count = COUNT_RESET;
    end else if (any_clear) begin
      next_timer_count = COUNT_RESET;
    end else if (tick) begin
      next_timer_count = timer_count + 16'h0001;
    end else begin
      next_timer_count = timer_count;
    end
  end

  // interrupts: match, or edge of the other input while capturing
  wire next_irq_a = match_a | (running & capture_a & valid_b);
  wire next_irq_b = match_b | (running & capture_b & valid_a);

  // ----------------------------------------------------------------
  // register write path
  // ----------------------------------------------------------------
  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire do_write = aw_full & w_full & ~S_AXI_BVALID;
  wire wr_cc_a = do_write & (aw_addr == OFS_CC_A);
  wire wr_cc_b = do_write & (aw_addr == OFS_CC_B);
  wire wr_mode = do_write & (aw_addr == OFS_MODE) & w_strb[0];
  wire wr_ccctl = do_write & (aw_addr == OFS_CCCTL) & w_strb[0];
  wire wr_outctl = do_write & (aw_addr == OFS_OUTCTL) & w_strb[0];
  wire wr_presc = do_write & (aw_addr == OFS_PRESC) & w_strb[0];
  // the count register accepts the access but keeps its value
  wire wr_known = (aw_addr == OFS_COUNT) | (aw_addr == OFS_CC_A) |
                  (aw_addr == OFS_CC_B) | (aw_addr == OFS_MODE) |
                  (aw_addr == OFS_CCCTL) | (aw_addr == OFS_OUTCTL) |
                  (aw_addr == OFS_PRESC);

  function automatic logic [CNT_W-1:0] merge16(
    input logic [CNT_W-1:0] old,
    input logic [DATA_W-1:0] data,
    input logic [3:0] strb
  );
    merge16 = {strb[1] ? data[15:8] : old[15:8],
               strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  wire [CNT_W-1:0] cc_a_wr = merge16(capture_compare_a, w_data, w_strb);
  wire [CNT_W-1:0] cc_b_wr = merge16(capture_compare_b, w_data, w_strb);
  wire [7:0] wbyte = w_data[7:0];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = {DATA_W{1'b0}};
    rd_ok = 1'b1;
    unique case (S_AXI_ARADDR)
      // stopped counter is held at zero, so a read returns zero
      OFS_COUNT: rd_word[CNT_W-1:0] = timer_count;
      OFS_CC_A: rd_word[CNT_W-1:0] = capture_compare_a;
      OFS_CC_B: rd_word[CNT_W-1:0] = capture_compare_b;
      OFS_MODE: begin
        rd_word[MODE_RUN_LO +: 2] = run_mode;
        rd_word[MODE_OVF] = overflow;
      end
      OFS_CCCTL: rd_word[2:0] = capcomp_control;
      OFS_OUTCTL: rd_word[7:0] = output_control;
      OFS_PRESC: rd_word[5:0] = prescaler_mode;
      default: rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= {DATA_W{1'b0}};
      w_strb <= 4'h0;
    end else begin
      S_AXI_AWREADY <= ~aw_full & ~aw_take;
      S_AXI_WREADY <= ~w_full & ~w_take;
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= {DATA_W{1'b0}};
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end else begin
        S_AXI_ARREADY <= ~S_AXI_RVALID;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      run_mode <= RUN_STOP;
      capcomp_control <= 3'h0;
      output_control <= CTL_RESET;
      prescaler_mode <= 6'h00;
      oneshot_trigger <= 1'b0;
    end else begin
      oneshot_trigger <= wr_outctl & wbyte[OUT_OS_TRIG];
      if (wr_mode) begin
        run_mode <= run_mode_t'(wbyte[MODE_RUN_LO +: 2]);
      end
      if (wr_ccctl) begin
        capcomp_control <= wbyte[2:0];
      end
      if (wr_outctl) begin
        // action bits never stay set
        output_control <= wbyte & ~((8'h01 << OUT_LOAD) |
                                    (8'h01 << OUT_OS_TRIG));
      end
      if (wr_presc) begin
        prescaler_mode <= wbyte[5:0];
      end
    end
  end

  // overflow: hardware set beats a software clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      overflow <= 1'b0;
    end else if (running & wrap & ~any_clear) begin
      overflow <= 1'b1;
    end else if (wr_mode & ~wbyte[MODE_OVF]) begin
      overflow <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // counter and capture/compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      timer_count <= COUNT_RESET;
    end else begin
      timer_count <= next_timer_count;
    end
  end

  // capture beats a simultaneous write; a capture racing a stop
  // still stores the count seen that cycle
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      capture_compare_a <= CC_RESET;
      capture_compare_b <= CC_RESET;
    end else begin
      if (cap_a) begin
        capture_compare_a <= timer_count;
      end else if (wr_cc_a) begin
        capture_compare_a <= cc_a_wr;
      end
      if (cap_b) begin
        capture_compare_b <= timer_count;
      end else if (wr_cc_b) begin
        capture_compare_b <= cc_b_wr;
      end
    end
  end

  // ----------------------------------------------------------------
  // timer output and interrupt pulses
  // ----------------------------------------------------------------
  wire out_en = output_control[OUT_ENABLE];
  wire toggle = (output_control[OUT_TOG_A] & match_a) ^
                (output_control[OUT_TOG_B] & match_b);

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      out_level <= 1'b0;
    end else if (wr_outctl & wbyte[OUT_LOAD]) begin
      out_level <= wbyte[OUT_INIT];
    end else if (out_en & oneshot_mode) begin
      // pulse starts at match b, ends at match a
      if (match_a) begin
        out_level <= 1'b0;
      end else if (match_b) begin
        out_level <= 1'b1;
      end
    end else if (out_en & toggle) begin
      out_level <= ~out_level;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      TIMER_OUTPUT <= 1'b0;
      MATCH_IRQ_A <= 1'b0;
      MATCH_IRQ_B <= 1'b0;
    end else begin
      TIMER_OUTPUT <= out_level;
      MATCH_IRQ_A <= next_irq_a;
      MATCH_IRQ_B <= next_irq_b;
    end
  end

endmodule : timer_event_counter
`default_nettype wire

// *** design/timer_pkg.sv ***
// shared constants for the 16-bit timer/event counter
package timer_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CC_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CC_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CCCTL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUTCTL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PRESC = 8'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_RUN_LO = 2;     // run mode bits [3:2]
  localparam int MODE_OVF = 0;        // overflow flag
  localparam int CC_A_CAPTURE = 0;    // 1: capture, 0: compare
  localparam int CC_A_REVPHASE = 1;   // 1: reverse edge of input a
  localparam int CC_B_CAPTURE = 2;
  localparam int OUT_ENABLE = 0;
  localparam int OUT_TOG_A = 1;
  localparam int OUT_TOG_B = 2;
  localparam int OUT_INIT = 3;
  localparam int OUT_LOAD = 4;        // write-one action
  localparam int OUT_ONESHOT = 5;
  localparam int OUT_OS_TRIG = 6;     // write-one action, reads zero
  localparam int OUT_OS_EDGE = 7;
  localparam int PRE_CLK_LO = 0;      // count clock select [1:0]
  localparam int PRE_EDGE_A_LO = 2;   // input a edge select [3:2]
  localparam int PRE_EDGE_B_LO = 4;   // input b edge select [5:4]
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CC_RESET = 16'h0000;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RUN_STOP = 2'h0,
    RUN_FREE = 2'h1,
    RUN_CLR_EDGE = 2'h2,
    RUN_CLR_MATCH = 2'h3
  } run_mode_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_NONE = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV16 = 2'h1;
  localparam logic [1:0] CLK_DIV256 = 2'h2;
  localparam logic [1:0] CLK_EXT_A = 2'h3;
  localparam logic [7:0] MASK_DIV2 = 8'h01;
  localparam logic [7:0] MASK_DIV16 = 8'h0F;
  localparam logic [7:0] MASK_DIV256 = 8'hFF;

endpackage : timer_pkg

// *** dv/pin_source.sv ***
// model of the outside world driving the two timer input pins
`timescale 1ns/100ps
`default_nettype none
module pin_source (
  input wire logic clk,
  output logic pin_a,
  output logic pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // levels held 4 clocks so the two-stage synchroniser sees each one
  task automatic pulse(input bit on_b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (on_b) pin_b <= 1'b1;
      else pin_a <= 1'b1;
      repeat (4) @(posedge clk);
      if (on_b) pin_b <= 1'b0;
      else pin_a <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask : pulse
endmodule : pin_source
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the timer/event counter
`timescale 1ns/100ps
`default_nettype none
module tb;
  import timer_pkg::*;
  logic clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pin_a, pin_b, tout;
  logic irq_a, irq_b, tout_d;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic [41:0] rd_q[$];
  logic [1:0] wr_q[$];
  int n_errors = 0;
  int checked = 0;
  int n_irq = 0;
  int n_tog = 0;
  int n_irq_b = 0;
  int cyc = 0, t_irq = 0, gap = 0;
  int n;
  integer seed = 32'he4348f5e;

  timer_event_counter dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TIMER_INPUT_A(pin_a),
    .TIMER_INPUT_B(pin_b), .TIMER_OUTPUT(tout), .MATCH_IRQ_A(irq_a),
    .MATCH_IRQ_B(irq_b));
  pin_source pins (.clk(clk_sys), .pin_a(pin_a), .pin_b(pin_b));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ------
  // comparisons and closing
  // ------
  task automatic cmp_rd(input logic [41:0] e, input logic [33:0] g);
    checked++;
    if (e[33:0] !== g) begin
      n_errors++;
      $display("CHECK FAILED read %h expected %h seen %h",
               e[41:34], e[33:0], g);
    end
  endtask : cmp_rd
  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (e !== g) begin
      n_errors++;
      $display("CHECK FAILED bresp expected %h seen %h", e, g);
    end
  endtask : cmp_wr
  task automatic cmp_cnt(input string s, input int e, input int g);
    checked++;
    if (e != g) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", s, e, g);
    end
  endtask : cmp_cnt
  task automatic stop_test;
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // outputs are judged against the oldest note of what was asked
  always @(posedge clk_sys) begin
    if (rvalid && rready) cmp_rd(rd_q.pop_front(), {rresp, rdata});
    if (bvalid && bready) cmp_wr(wr_q.pop_front(), bresp);
    cyc++;
    if (irq_a === 1'b1) begin
      n_irq++;
      gap = cyc - t_irq;
      t_irq = cyc;
    end
    if (irq_b === 1'b1) n_irq_b++;
    if (tout !== tout_d) n_tog++;
    tout_d <= tout;
  end
  // ------
  // bus master
  // ------
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r = RESP_OKAY);
    bit aw_ok = 0;
    bit w_ok = 0;
    wr_q.push_back(r);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (awvalid && awready) aw_ok = 1;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) w_ok = 1;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = RESP_OKAY);
    rd_q.push_back({a, r, e});
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end
  // ------
  // scenarios
  // ------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, tout_d} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    rst_b = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(OFS_COUNT, 32'h0);
    rd(OFS_CC_A, 32'h0);
    rd(OFS_CC_B, 32'h0);
    rd(OFS_MODE, 32'h0);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'h1, RESP_SLVERR);
    wr(OFS_COUNT, 32'hFFFF);
    rd(OFS_COUNT, 32'h0);
    // count on rising edges of input a, input b edges rising too
    wr(OFS_PRESC, 32'h17);
    wr(OFS_MODE, 32'h04);
    n = 1 + ($random(seed) & 15);
    pins.pulse(0, n);
    rd(OFS_COUNT, 32'(n));
    d = $random(seed);
    wr(OFS_CC_B, d);
    rd(OFS_CC_B, {16'h0, d[15:0]});
    wr(OFS_OUTCTL, 32'h60);
    rd(OFS_COUNT, 32'h0);
    wr(OFS_OUTCTL, 32'h0);
    wr(OFS_MODE, 32'h0);
    rd(OFS_COUNT, 32'h0);
    wr(OFS_CC_A, 32'h3);
    wr(OFS_OUTCTL, 32'h3);
    n_irq = 0;
    n_tog = 0;
    wr(OFS_MODE, 32'h0C);
    n = 4 + ($random(seed) & 15);
    pins.pulse(0, n);
    rd(OFS_COUNT, 32'(n % 4));
    cmp_cnt("match irq a", n / 4, n_irq);
    cmp_cnt("output toggles", n / 4, n_tog);
    wr(OFS_OUTCTL, 32'h0);
    wr(OFS_MODE, 32'h0);
    wr(OFS_MODE, 32'h04);
    pins.pulse(1, 2);
    rd(OFS_CC_A, 32'h3);
    wr(OFS_MODE, 32'h0);
    // each input a edge both ticks and clears, so the count stays at zero
    wr(OFS_CCCTL, 32'h4);
    wr(OFS_MODE, 32'h08);
    n_irq_b = 0;
    pins.pulse(0, 3);
    rd(OFS_COUNT, 32'h0);
    rd(OFS_CC_B, 32'h0);
    cmp_cnt("capture irq b", 3, n_irq_b);
    wr(OFS_MODE, 32'h0);
    wr(OFS_CCCTL, 32'h1);
    wr(OFS_MODE, 32'h04);
    n = 1 + ($random(seed) & 15);
    pins.pulse(0, n);
    pins.pulse(1, 1);
    pins.pulse(0, 2);
    wr(OFS_MODE, 32'h0);
    rd(OFS_CC_A, 32'(n));
    rd(OFS_COUNT, 32'h0);
    wr(OFS_CCCTL, 32'h0);
    wr(OFS_CC_A, 32'h5);
    rd(OFS_CC_A, 32'h5);
    // interval: (5 + 1) ticks of the divide-by-two count clock
    wr(OFS_PRESC, 32'h14);
    wr(OFS_MODE, 32'h0C);
    repeat (40) @(posedge clk_sys);
    cmp_cnt("irq a interval", 12, gap);
    repeat (4) @(posedge clk_sys);
    stop_test();
  end
endmodule : tb
`default_nettype wire

// *** dv/timer_checker.sv ***
// bus and interrupt port assertions for the timer/event counter
`timescale 1ns/100ps
`default_nettype none
module timer_checker (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [timer_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [timer_pkg::DATA_W-1:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic MATCH_IRQ_A,
  input wire logic MATCH_IRQ_B
);
  import timer_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // ------
  // read and write handshake steps
  // ------
  sequence s_ar_taken; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  sequence s_r_answer; S_AXI_RVALID && !S_AXI_ARREADY; endsequence
  sequence s_b_done; S_AXI_BVALID && S_AXI_BREADY; endsequence
  sequence s_wr_free; !S_AXI_BVALID ##1 S_AXI_AWREADY && S_AXI_WREADY;
  endsequence
  property p_ar_answer; s_ar_taken |=> s_r_answer; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
  property p_unmapped;
    s_ar_taken ##0 S_AXI_ARADDR > 8'h1B |=>
      S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_upper_zero; S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits set");
  property p_aw_refused; S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY;
  endproperty
  a_aw_refused: assert property (p_aw_refused) else $error("aw not refused");
  property p_w_refused; S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_WREADY;
  endproperty
  a_w_refused: assert property (p_w_refused) else $error("w not refused");
  property p_b_release; s_b_done |=> s_wr_free; endproperty
  a_b_release: assert property (p_b_release) else $error("write not freed");
  property p_r_release;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY;
  endproperty
  a_r_release: assert property (p_r_release) else $error("read not freed");
  property p_irq_a_pulse; MATCH_IRQ_A |=> !MATCH_IRQ_A; endproperty
  a_irq_a_pulse: assert property (p_irq_a_pulse)
    else $error("irq a too long");
  property p_irq_b_pulse; MATCH_IRQ_B |=> !MATCH_IRQ_B; endproperty
  a_irq_b_pulse: assert property (p_irq_b_pulse)
    else $error("irq b too long");
endmodule : timer_checker
bind timer_event_counter timer_checker u_checker (.CLK_SYS(CLK_SYS),
  .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .MATCH_IRQ_A(MATCH_IRQ_A), .MATCH_IRQ_B(MATCH_IRQ_B));
`default_nettype wire
